// >>> core/timer_ccp_pkg.sv
// constants and types shared by the period timer and capture/compare block
package timer_ccp_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_FLAG = 10'h00c;
    localparam logic [9:0] IDX_COUNT = 10'h011;
    localparam logic [9:0] IDX_CTRL = 10'h012;
    localparam logic [9:0] IDX_VAL_LO = 10'h015;
    localparam logic [9:0] IDX_VAL_HI = 10'h016;
    localparam logic [9:0] IDX_CCCTRL = 10'h017;
    localparam logic [9:0] IDX_ENABLE = 10'h08c;
    localparam logic [9:0] IDX_PERIOD = 10'h092;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;
    // ==========================================================
    // field positions
    localparam int CC_FLAG_BIT = 2;
    localparam int TM_FLAG_BIT = 1;
    localparam int POST_LSB = 3;
    localparam int RUN_BIT = 2;
    localparam int PRE_LSB = 0;
    localparam int DUTY_LSB = 4;
    localparam int MODE_LSB = 0;
    // ==========================================================
    // reset values and implemented-bit masks
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [7:0] CTRL_MASK = 8'h7f;
    localparam logic [7:0] CCCTRL_MASK = 8'h3f;
    localparam logic [7:0] FLAG_MASK = 8'h06;
    localparam logic [7:0] ENABLE_MASK = 8'h06;
    localparam logic [23:0] RD_PAD = 24'h000000;
    // ==========================================================
    // mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] CAP_FALL = 4'h4;
    localparam logic [3:0] CAP_RISE = 4'h5;
    localparam logic [3:0] CAP_4TH = 4'h6;
    localparam logic [3:0] CAP_16TH = 4'h7;
    localparam logic [3:0] CMP_SET = 4'h8;
    localparam logic [3:0] CMP_CLR = 4'h9;
    localparam logic [3:0] CMP_SOFT = 4'ha;
    localparam logic [3:0] CMP_TRIG = 4'hb;
    localparam logic [1:0] PWM_TOP = 2'h3;
    // ==========================================================
    // divider limits (terminal count of each divider)
    localparam logic [1:0] PRE_SEL_1 = 2'h0;
    localparam logic [1:0] PRE_SEL_4 = 2'h1;
    localparam logic [3:0] PRE_LIM_1 = 4'h0;
    localparam logic [3:0] PRE_LIM_4 = 4'h3;
    localparam logic [3:0] PRE_LIM_16 = 4'hf;
    localparam logic [3:0] CAP_LIM_4 = 4'h3;
    localparam logic [3:0] CAP_LIM_16 = 4'hf;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONE = 4'h1;
    localparam logic [7:0] CNT_ONE = 8'h01;
    typedef enum logic [1:0] {cls_off, cls_capture, cls_compare, cls_pwm} mode_class_e;
endpackage : timer_ccp_pkg

// >>> core/period_timer_ccp.sv
// period timer with pre/post dividers and capture/compare/pwm mode control
// What this block does
// - writes to count or control, and reset, clear both divider counters
// - writing the control register leaves the timer count unchanged
// - the match before the post divider goes out to the serial port
// - count climbs from zero to period, then wraps to zero next increment
// - post divided match sets the match flag; software clears it
// - timer input is instruction clock divided by 1, 4 or 16
// - clearing the run bit stops the timer
// - one 16-bit value register serves capture, compare or pwm duty
// - value register is reached as separate low and high bytes
// - both value bytes and unit control are readable and writable
// - capture/compare use the wide timer; pwm uses the period timer
// - mode 0000 switches the unit off and resets its state
// - 0100 captures on falling pin edge, 0101 on rising
// - 0110 captures every 4th rising edge, 0111 every 16th
// - 1000 drives output high on match and sets event flag
// - 1001 drives output low on match and sets event flag
// - 1010 sets event flag on match, pin left alone
// - 1011 sets event flag and fires trigger resetting wide timer
// - 11xx is pwm; control bits 5-4 are duty low bits
// - duty low bits do nothing outside pwm mode
module period_timer_ccp (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [timer_ccp_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // wide timer side
    input wire logic [15:0] wide_timer_count,
    output logic special_event,
    // serial port shift clock source
    output logic timer_match_out,
    // unit pin
    input wire logic cc_pin_in,
    output logic cc_pin_out,
    output logic cc_pin_oe
);
    // ==========================================================
    // functions
    function automatic logic [3:0] pre_limit(input logic [1:0] sel);
        logic [3:0] lim;
        lim = timer_ccp_pkg::PRE_LIM_16;
        if (sel == timer_ccp_pkg::PRE_SEL_1) begin
            lim = timer_ccp_pkg::PRE_LIM_1;
        end else if (sel == timer_ccp_pkg::PRE_SEL_4) begin
            lim = timer_ccp_pkg::PRE_LIM_4;
        end
        return lim;
    endfunction : pre_limit

    function automatic timer_ccp_pkg::mode_class_e mode_class(input logic [3:0] m);
        timer_ccp_pkg::mode_class_e c;
        c = timer_ccp_pkg::cls_off;
        if (m[3:2] == timer_ccp_pkg::PWM_TOP) begin
            c = timer_ccp_pkg::cls_pwm;
        end else if (m[3]) begin
            c = timer_ccp_pkg::cls_compare;
        end else if (m[2]) begin
            c = timer_ccp_pkg::cls_capture;
        end
        return c;
    endfunction : mode_class

    // ==========================================================
    // state
    logic [7:0] timer_count;
    logic [7:0] timer_period;
    logic [7:0] timer_control;
    logic [7:0] capture_compare_control;
    logic [7:0] cc_value_low;
    logic [7:0] cc_value_high;
    logic [7:0] peripheral_flag_register;
    logic [7:0] peripheral_enable_register;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic [3:0] cap_cnt;
    logic pin_q;
    logic cmp_eq_q;

    // ==========================================================
    // apb decode
    wire [9:0] idx = paddr[timer_ccp_pkg::ADDR_W-1:timer_ccp_pkg::IDX_LSB];
    wire hit_flag = idx == timer_ccp_pkg::IDX_FLAG;
    wire hit_count = idx == timer_ccp_pkg::IDX_COUNT;
    wire hit_ctrl = idx == timer_ccp_pkg::IDX_CTRL;
    wire hit_lo = idx == timer_ccp_pkg::IDX_VAL_LO;
    wire hit_hi = idx == timer_ccp_pkg::IDX_VAL_HI;
    wire hit_cc = idx == timer_ccp_pkg::IDX_CCCTRL;
    wire hit_en = idx == timer_ccp_pkg::IDX_ENABLE;
    wire hit_per = idx == timer_ccp_pkg::IDX_PERIOD;
    wire hit_any = hit_flag | hit_count | hit_ctrl | hit_lo | hit_hi | hit_cc | hit_en | hit_per;
    wire access = psel & penable;
    wire wr = access & pwrite & hit_any;
    wire [7:0] wbyte = pwdata[7:0];
    wire wr_flag = wr & hit_flag;
    wire wr_count = wr & hit_count;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_lo = wr & hit_lo;
    wire wr_hi = wr & hit_hi;
    wire wr_cc = wr & hit_cc;
    wire wr_en = wr & hit_en;
    wire wr_per = wr & hit_per;

    assign pready = access;
    assign pslverr = access & ~hit_any;

    // ==========================================================
    // read mux (unmapped reads as zero)
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = timer_ccp_pkg::BYTE_ZERO;
        if (hit_flag) rd_byte = peripheral_flag_register;
        if (hit_count) rd_byte = timer_count;
        if (hit_ctrl) rd_byte = timer_control;
        if (hit_lo) rd_byte = cc_value_low;
        if (hit_hi) rd_byte = cc_value_high;
        if (hit_cc) rd_byte = capture_compare_control;
        if (hit_en) rd_byte = peripheral_enable_register;
        if (hit_per) rd_byte = timer_period;
    end

    // data captured in the setup phase, held through the access phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= {timer_ccp_pkg::RD_PAD, timer_ccp_pkg::BYTE_ZERO};
        end else if (psel & ~penable) begin
            prdata <= {timer_ccp_pkg::RD_PAD, rd_byte};
        end
    end

    // ==========================================================
    // period timer
    wire run = timer_control[timer_ccp_pkg::RUN_BIT];
    wire [1:0] pre_sel = timer_control[timer_ccp_pkg::PRE_LSB +: 2];
    wire [3:0] post_sel = timer_control[timer_ccp_pkg::POST_LSB +: 4];
    wire [3:0] pre_lim = pre_limit(pre_sel);
    wire pre_tick = run & (pre_cnt == pre_lim);
    wire at_period = timer_count == timer_period;
    wire div_clear = wr_count | wr_ctrl;
    wire post_hit = timer_match_out & (post_cnt == post_sel);

    assign timer_match_out = pre_tick & at_period;

    wire [3:0] next_pre = (div_clear | pre_tick) ? timer_ccp_pkg::NIB_ZERO
                        : run ? pre_cnt + timer_ccp_pkg::NIB_ONE : pre_cnt;
    wire [3:0] next_post = div_clear ? timer_ccp_pkg::NIB_ZERO
                         : post_hit ? timer_ccp_pkg::NIB_ZERO
                         : timer_match_out ? post_cnt + timer_ccp_pkg::NIB_ONE : post_cnt;
    wire [7:0] next_count = wr_count ? wbyte
                          : timer_match_out ? timer_ccp_pkg::BYTE_ZERO
                          : pre_tick ? timer_count + timer_ccp_pkg::CNT_ONE : timer_count;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pre_cnt <= timer_ccp_pkg::NIB_ZERO;
            post_cnt <= timer_ccp_pkg::NIB_ZERO;
            timer_count <= timer_ccp_pkg::BYTE_ZERO;
        end else begin
            pre_cnt <= next_pre;
            post_cnt <= next_post;
            timer_count <= next_count;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_control <= timer_ccp_pkg::BYTE_ZERO;
            timer_period <= timer_ccp_pkg::PERIOD_RST;
            peripheral_enable_register <= timer_ccp_pkg::BYTE_ZERO;
        end else begin
            if (wr_ctrl) timer_control <= wbyte & timer_ccp_pkg::CTRL_MASK;
            if (wr_per) timer_period <= wbyte;
            if (wr_en) peripheral_enable_register <= wbyte & timer_ccp_pkg::ENABLE_MASK;
        end
    end

    // ==========================================================
    // capture/compare/pwm mode control
    wire [3:0] mode = capture_compare_control[timer_ccp_pkg::MODE_LSB +: 4];
    wire [1:0] duty_low = capture_compare_control[timer_ccp_pkg::DUTY_LSB +: 2];
    timer_ccp_pkg::mode_class_e cls;
    assign cls = mode_class(mode);
    wire is_cap = cls == timer_ccp_pkg::cls_capture;
    wire is_cmp = cls == timer_ccp_pkg::cls_compare;
    wire is_pwm = cls == timer_ccp_pkg::cls_pwm;
    wire is_off = mode == timer_ccp_pkg::MODE_OFF;

    // capture edge selection
    wire rise = cc_pin_in & ~pin_q;
    wire fall = ~cc_pin_in & pin_q;
    wire scaled = (mode == timer_ccp_pkg::CAP_4TH) | (mode == timer_ccp_pkg::CAP_16TH);
    wire [3:0] cap_lim = (mode == timer_ccp_pkg::CAP_4TH) ? timer_ccp_pkg::CAP_LIM_4 : timer_ccp_pkg::CAP_LIM_16;
    wire cap_event = is_cap & ((mode == timer_ccp_pkg::CAP_FALL) & fall
                             | (mode == timer_ccp_pkg::CAP_RISE) & rise
                             | scaled & rise & (cap_cnt == cap_lim));
    wire [3:0] next_cap = ~is_cap ? timer_ccp_pkg::NIB_ZERO
                        : (scaled & rise) ? ((cap_cnt == cap_lim) ? timer_ccp_pkg::NIB_ZERO
                                                                  : cap_cnt + timer_ccp_pkg::NIB_ONE)
                        : cap_cnt;

    // compare against the wide timer, one hit per new match
    wire cmp_eq = {cc_value_high, cc_value_low} == wide_timer_count;
    wire cmp_hit = is_cmp & cmp_eq & ~cmp_eq_q;
    assign special_event = cmp_hit & (mode == timer_ccp_pkg::CMP_TRIG);

    // pwm: duty against the period timer extended by two divider bits
    wire pwm_level = {timer_count, pre_cnt[1:0]} < {cc_value_low, duty_low};
    assign cc_pin_oe = is_pwm | (mode == timer_ccp_pkg::CMP_SET) | (mode == timer_ccp_pkg::CMP_CLR);

    wire next_pin = is_off ? 1'b0
                  : is_pwm ? pwm_level
                  : (cmp_hit & (mode == timer_ccp_pkg::CMP_SET)) ? 1'b1
                  : (cmp_hit & (mode == timer_ccp_pkg::CMP_CLR)) ? 1'b0
                  : cc_pin_out;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap_cnt <= timer_ccp_pkg::NIB_ZERO;
            pin_q <= 1'b0;
            cmp_eq_q <= 1'b0;
            cc_pin_out <= 1'b0;
        end else begin
            cap_cnt <= next_cap;
            pin_q <= cc_pin_in;
            cmp_eq_q <= cmp_eq & is_cmp;
            cc_pin_out <= next_pin;
        end
    end

    // value register: a capture wins over a bus write in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            capture_compare_control <= timer_ccp_pkg::BYTE_ZERO;
            cc_value_low <= timer_ccp_pkg::BYTE_ZERO;
            cc_value_high <= timer_ccp_pkg::BYTE_ZERO;
        end else begin
            if (wr_cc) capture_compare_control <= wbyte & timer_ccp_pkg::CCCTRL_MASK;
            if (cap_event) begin
                cc_value_low <= wide_timer_count[7:0];
                cc_value_high <= wide_timer_count[15:8];
            end else begin
                if (wr_lo) cc_value_low <= wbyte;
                if (wr_hi) cc_value_high <= wbyte;
            end
        end
    end

    // ==========================================================
    // flags: hardware set wins over a software clear
    wire set_cc = cap_event | cmp_hit;
    wire [7:0] flag_base = wr_flag ? (wbyte & timer_ccp_pkg::FLAG_MASK) : peripheral_flag_register;
    wire [7:0] flag_set = {5'h00, set_cc, post_hit, 1'b0};
    wire [7:0] next_flag = flag_base | flag_set;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            peripheral_flag_register <= timer_ccp_pkg::BYTE_ZERO;
        end else begin
            peripheral_flag_register <= next_flag;
        end
    end

    // ==========================================================
    // assertions
    sequence quiet4_s;
        (!div_clear && run && pre_sel == timer_ccp_pkg::PRE_SEL_4) [*4];
    endsequence

    presc_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        div_clear |=> (pre_cnt == timer_ccp_pkg::NIB_ZERO && post_cnt == timer_ccp_pkg::NIB_ZERO))
        else $error("divider counters not cleared after write");
    ctrl_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && !pre_tick |=> timer_count == $past(timer_count))
        else $error("control write changed timer count");
    wrap_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_match_out && !wr_count |=> timer_count == timer_ccp_pkg::BYTE_ZERO)
        else $error("timer did not wrap after period match");
    run_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !run && !wr_count |=> $stable(timer_count))
        else $error("stopped timer moved");
    run_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !run |-> !timer_match_out)
        else $error("stopped timer raised a match");
    div4_space_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pre_tick && pre_sel == timer_ccp_pkg::PRE_SEL_4 ##1 quiet4_s |-> pre_tick)
        else $error("divide by four spacing wrong");
    match_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        post_hit |=> peripheral_flag_register[timer_ccp_pkg::TM_FLAG_BIT])
        else $error("post divided match did not set flag");
    cap_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_event |=> {cc_value_high, cc_value_low} == $past(wide_timer_count)
                      && peripheral_flag_register[timer_ccp_pkg::CC_FLAG_BIT])
        else $error("capture did not load value and flag");
    off_state_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_off |=> !cc_pin_out && cap_cnt == timer_ccp_pkg::NIB_ZERO)
        else $error("off mode left unit state");
    cmp_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp_hit && mode == timer_ccp_pkg::CMP_SET |=> cc_pin_out)
        else $error("compare set mode did not drive high");
    trig_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        special_event |=> !special_event)
        else $error("special event trigger longer than one cycle");
endmodule : period_timer_ccp

// >>> dv/wide_timer_model.sv
// behavioural 16-bit timer standing beside the capture/compare unit
module wide_timer_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control from the bench and trigger from the unit
    input wire logic run,
    input wire logic special_event,
    // count seen by capture and compare
    output logic [15:0] wide_timer_count
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wide_timer_count <= 16'h0000;
        end else if (special_event) begin
            wide_timer_count <= 16'h0000;
        end else if (run) begin
            wide_timer_count <= wide_timer_count + 16'h0001;
        end
    end
endmodule : wide_timer_model

// >>> dv/tb_period_timer_ccp.sv
// self-checking bench for the period timer and capture/compare block
module tb_period_timer_ccp;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // signals
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] wide_timer_count;
    logic special_event;
    logic timer_match_out;
    logic cc_pin_in = 1'b0;
    logic cc_pin_out;
    logic cc_pin_oe;
    logic wrun = 1'b1;
    logic [31:0] rdv;
    logic errv;
    logic [15:0] t;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int last = 0;
    int ival = 0;
    int npulse = 0;
    int hcount = 0;
    int nsev = 0;
    int s0;
    int n;
    period_timer_ccp u_period_timer_ccp (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .wide_timer_count, .special_event, .timer_match_out, .cc_pin_in,
        .cc_pin_out, .cc_pin_oe);
    wide_timer_model u_wide_timer_model (.core_clk, .rst_n, .run(wrun), .special_event, .wide_timer_count);
    always #12.5 core_clk = ~core_clk;
    // ==========================================================
    // monitors of match pulses, pin high time and trigger pulses
    always @(negedge core_clk) begin
        cyc++;
        hcount += int'(cc_pin_out === 1'b1);
        nsev += int'(special_event === 1'b1);
        if (timer_match_out === 1'b1) begin
            ival = cyc - last;
            last = cyc;
            npulse++;
        end
    end
    // ==========================================================
    // tasks
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h000000, exp}, rdv);
    endtask : rd
    task automatic wflag(input int b);
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, timer_ccp_pkg::IDX_FLAG, 8'h00);
            if (rdv[b] === 1'b1) break;
        end
        chk("flag bit", 32'h1, 32'(rdv[b]));
    endtask : wflag
    task automatic pin(input logic b);
        cc_pin_in <= b;
        repeat (3) @(posedge core_clk);
    endtask : pin
    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd("flag", timer_ccp_pkg::IDX_FLAG, 8'h00);
        rd("count", timer_ccp_pkg::IDX_COUNT, 8'h00);
        rd("ctrl", timer_ccp_pkg::IDX_CTRL, 8'h00);
        rd("ccctrl", timer_ccp_pkg::IDX_CCCTRL, 8'h00);
        rd("period", timer_ccp_pkg::IDX_PERIOD, 8'hff);
        rd("enable", timer_ccp_pkg::IDX_ENABLE, 8'h00);
        rd("unmapped", 10'h001, 8'h00);
        chk("slverr", 32'h1, 32'(errv));
        wr(timer_ccp_pkg::IDX_ENABLE, 8'hff);
        rd("enable", timer_ccp_pkg::IDX_ENABLE, 8'h06);
        wr(timer_ccp_pkg::IDX_CTRL, 8'hfb);
        rd("ctrl", timer_ccp_pkg::IDX_CTRL, 8'h7b);
        wr(timer_ccp_pkg::IDX_COUNT, 8'h05);
        wr(timer_ccp_pkg::IDX_CTRL, 8'h78);
        rd("count", timer_ccp_pkg::IDX_COUNT, 8'h05);
        repeat (20) @(posedge core_clk);
        rd("count stopped", timer_ccp_pkg::IDX_COUNT, 8'h05);
        wr(timer_ccp_pkg::IDX_CCCTRL, 8'hff);
        rd("ccctrl", timer_ccp_pkg::IDX_CCCTRL, 8'h3f);
        wr(timer_ccp_pkg::IDX_VAL_LO, 8'ha5);
        wr(timer_ccp_pkg::IDX_VAL_HI, 8'h5a);
        rd("val lo", timer_ccp_pkg::IDX_VAL_LO, 8'ha5);
        rd("val hi", timer_ccp_pkg::IDX_VAL_HI, 8'h5a);
        // match spacing for each pre divide code, period 2
        wr(timer_ccp_pkg::IDX_PERIOD, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(timer_ccp_pkg::IDX_CTRL, {5'h00, 1'b1, 2'(c)});
            s0 = npulse;
            for (int i = 0; i < 300 && npulse < s0 + 2; i++) @(posedge core_clk);
            chk("match spacing", 32'(3 * (c == 0 ? 1 : (c == 1 ? 4 : 16))), 32'(ival));
        end
        // matches needed before the flag, period 0, divide by 16
        wr(timer_ccp_pkg::IDX_PERIOD, 8'h00);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : ((k == 1) ? 3 : 15);
            wr(timer_ccp_pkg::IDX_CTRL, {1'b0, 4'(n), 1'b0, 2'h2});
            wr(timer_ccp_pkg::IDX_COUNT, 8'h00);
            wr(timer_ccp_pkg::IDX_FLAG, 8'h00);
            wr(timer_ccp_pkg::IDX_CTRL, {1'b0, 4'(n), 1'b1, 2'h2});
            npulse = 0;
            wflag(1);
            chk("post count", 32'(n + 1), 32'(npulse));
        end
        wr(timer_ccp_pkg::IDX_CTRL, 8'h00);
        // capture modes: falling, rising, every 4th, every 16th
        for (int m = 4; m < 8; m++) begin
            n = (m == 6) ? 4 : ((m == 7) ? 16 : 1);
            wr(timer_ccp_pkg::IDX_CCCTRL, 8'h00);
            wr(timer_ccp_pkg::IDX_VAL_LO, 8'h00);
            wr(timer_ccp_pkg::IDX_VAL_HI, 8'h00);
            repeat (9 + m) @(posedge core_clk);
            wrun <= 1'b0;
            @(posedge core_clk);
            t = wide_timer_count;
            wr(timer_ccp_pkg::IDX_CCCTRL, 8'(m));
            wr(timer_ccp_pkg::IDX_FLAG, 8'h00);
            for (int i = 1; i < n; i++) begin
                pin(1'b1);
                pin(1'b0);
            end
            apb(1'b0, timer_ccp_pkg::IDX_FLAG, 8'h00);
            chk("early capture", 32'h0, 32'(rdv[2]));
            pin(1'b1);
            if (m == 4) begin
                apb(1'b0, timer_ccp_pkg::IDX_FLAG, 8'h00);
                chk("rise in fall mode", 32'h0, 32'(rdv[2]));
                pin(1'b0);
            end
            wflag(2);
            rd("cap lo", timer_ccp_pkg::IDX_VAL_LO, t[7:0]);
            rd("cap hi", timer_ccp_pkg::IDX_VAL_HI, t[15:8]);
            pin(1'b0);
            wrun <= 1'b1;
        end
        // compare modes: set, clear, flag only, trigger
        for (int m = 8; m < 12; m++) begin
            wrun <= 1'b0;
            @(posedge core_clk);
            t = wide_timer_count + 16'h001e;
            wr(timer_ccp_pkg::IDX_VAL_LO, t[7:0]);
            wr(timer_ccp_pkg::IDX_VAL_HI, t[15:8]);
            wr(timer_ccp_pkg::IDX_CCCTRL, 8'(m));
            wr(timer_ccp_pkg::IDX_FLAG, 8'h00);
            s0 = nsev;
            wrun <= 1'b1;
            wflag(2);
            chk("pin", 32'(m == 8), 32'(cc_pin_out));
            chk("oe", 32'(m < 10), 32'(cc_pin_oe));
            chk("trigger pulses", 32'(m == 11), 32'(nsev - s0));
        end
        chk("wide reset", 32'h1, 32'(wide_timer_count < t));
        // pwm high time over one period of 40 clocks
        wr(timer_ccp_pkg::IDX_PERIOD, 8'h09);
        wr(timer_ccp_pkg::IDX_VAL_LO, 8'h05);
        for (int k = 0; k < 2; k++) begin
            wr(timer_ccp_pkg::IDX_CCCTRL, (k == 0) ? 8'h2c : 8'h1f);
            wr(timer_ccp_pkg::IDX_CTRL, 8'h05);
            repeat (50) @(posedge core_clk);
            s0 = hcount;
            repeat (40) @(posedge core_clk);
            chk("pwm high", (k == 0) ? 32'd22 : 32'd21, 32'(hcount - s0));
            chk("pwm oe", 32'h1, 32'(cc_pin_oe));
        end
        wr(timer_ccp_pkg::IDX_CCCTRL, 8'h00);
        s0 = hcount;
        repeat (20) @(posedge core_clk);
        chk("off high", 32'h0, 32'(hcount - s0));
        chk("off oe", 32'h0, 32'(cc_pin_oe));
        give_verdict();
    end
    initial begin
        #500000;
        err_total++;
        give_verdict();
    end
endmodule : tb_period_timer_ccp
